// >>> scp_pkg.sv
package scp_pkg;

    // ********************************************************
    // Register map and field layout
    // ********************************************************
    localparam int           NUM_REGS           = 26;
    localparam logic [4:0]   CFG_ADDR           = 5'h00;
    localparam logic [4:0]   ADDR_FIRST         = 5'h00;
    localparam logic [4:0]   ADDR_LAST          = 5'h19;
    localparam int           CFG_INPUT_ONLY_BIT = 7;
    localparam int           CFG_LSB_FIRST_BIT  = 6;
    localparam logic [7:0]   REG_RESET          = 8'h00;

    // ********************************************************
    // Instruction byte layout and bit counting
    // ********************************************************
    localparam int           INSTR_RD_BIT       = 7;
    localparam int           INSTR_CNT_MSB      = 6;
    localparam int           INSTR_CNT_LSB      = 5;
    localparam int           INSTR_ADDR_MSB     = 4;
    localparam logic [2:0]   BIT_FIRST          = 3'h0;
    localparam logic [2:0]   BIT_LAST           = 3'h7;
    localparam logic [1:0]   BYTES_LAST         = 2'h0;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int           SCLK_MAX_HZ        = 10_000_000;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [0:0] {
        PH_INSTR = 1'b0,
        PH_DATA  = 1'b1
    } scp_phase_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } scp_wr_t;

    typedef struct packed {
        scp_phase_t phase;
        logic [2:0] bit_cnt;
        logic [1:0] bytes_left;
        logic [4:0] addr;
        logic       rd;
        logic [7:0] shift;
    } scp_port_t;

endpackage

// >>> scp_serial_control_port.sv
`timescale 1ns/100ps

module scp_serial_control_port #(
    parameter int NUM_REGS = scp_pkg::NUM_REGS
) (
    input  wire logic                      clock,             // Core clock, 100 MHz
    input  wire logic                      rst_n,             // Async reset, active low
    input  wire logic                      sclk,              // Serial clock from host
    input  wire logic                      cs_n,              // Chip select, active low
    input  wire logic                      port_resync,       // Port state abort, active high
    input  wire logic                      sdio_in,           // Shared data pin, input side
    output logic                           sdio_out,          // Shared data pin, output side
    output logic                           sdio_oe,           // Shared data pin drive enable
    output logic                           serial_out_pin,    // Separate serial output
    output logic                           serial_out_pin_oe, // Separate output drive enable
    output logic [NUM_REGS-1:0][7:0]       reg_bank,          // Register image, core domain
    output logic                           reg_update         // Pulse on each image update
);

    // ********************************************************
    // Parameter check
    // ********************************************************
    if (NUM_REGS <= int'(scp_pkg::ADDR_LAST) || NUM_REGS > 32)
    begin : g_bad_regs
        $error("NUM_REGS must cover the wrap address and fit five address bits");
    end

    // ********************************************************
    // Serial clock domain: port state
    // ********************************************************
    logic                       link_rst_n;
    scp_pkg::scp_port_t         port_q;
    scp_pkg::scp_port_t         port_d;
    logic [NUM_REGS-1:0][7:0]   regs_q;
    logic [NUM_REGS-1:0][7:0]   regs_d;
    scp_pkg::scp_wr_t           wr_q;
    scp_pkg::scp_wr_t           wr_d;
    logic                       wr_tgl_q;
    logic                       wr_tgl_d;
    logic                       lsb_first;
    logic                       input_only;
    logic [7:0]                 din_byte;
    logic [4:0]                 step_addr;
    logic                       addr_ok;

    assign link_rst_n = rst_n & ~port_resync;
    assign lsb_first  = regs_q[scp_pkg::CFG_ADDR][scp_pkg::CFG_LSB_FIRST_BIT];
    assign input_only = regs_q[scp_pkg::CFG_ADDR][scp_pkg::CFG_INPUT_ONLY_BIT];
    assign addr_ok    = int'(port_q.addr) < NUM_REGS;

    always_comb
    begin
        port_d    = port_q;
        regs_d    = regs_q;
        wr_d      = wr_q;
        wr_tgl_d  = wr_tgl_q;
        din_byte  = lsb_first ? {sdio_in, port_q.shift[7:1]}
                              : {port_q.shift[6:0], sdio_in};
        if (lsb_first)
        begin
            step_addr = (port_q.addr == scp_pkg::ADDR_LAST) ? scp_pkg::ADDR_FIRST
                                                            : 5'(port_q.addr + 5'h01);
        end
        else
        begin
            step_addr = (port_q.addr == scp_pkg::ADDR_FIRST) ? scp_pkg::ADDR_LAST
                                                             : 5'(port_q.addr - 5'h01);
        end
        if (!cs_n)
        begin
            port_d.shift   = din_byte;
            port_d.bit_cnt = 3'(port_q.bit_cnt + 3'h1);
            if (port_q.bit_cnt == scp_pkg::BIT_LAST)
            begin
                if (port_q.phase == scp_pkg::PH_INSTR)
                begin
                    port_d.phase      = scp_pkg::PH_DATA;
                    port_d.rd         = din_byte[scp_pkg::INSTR_RD_BIT];
                    port_d.bytes_left = din_byte[scp_pkg::INSTR_CNT_MSB:scp_pkg::INSTR_CNT_LSB];
                    port_d.addr       = din_byte[scp_pkg::INSTR_ADDR_MSB:0];
                end
                else
                begin
                    if (!port_q.rd && addr_ok)
                    begin
                        regs_d[port_q.addr] = din_byte;
                        wr_d.addr           = port_q.addr;
                        wr_d.data           = din_byte;
                        wr_tgl_d            = ~wr_tgl_q;
                    end
                    port_d.addr       = step_addr;
                    port_d.bytes_left = 2'(port_q.bytes_left - 2'h1);
                    if (port_q.bytes_left == scp_pkg::BYTES_LAST)
                    begin
                        port_d.phase = scp_pkg::PH_INSTR;
                    end
                end
            end
        end
    end

    // Port state is cleared by resync; register contents are not
    always_ff @(posedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            port_q <= '{phase: scp_pkg::PH_INSTR, bit_cnt: scp_pkg::BIT_FIRST,
                        bytes_left: scp_pkg::BYTES_LAST, addr: scp_pkg::ADDR_FIRST,
                        rd: 1'b0, shift: 8'h00};
        end
        else
        begin
            port_q <= port_d;
        end
    end

    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regs_q   <= {NUM_REGS{scp_pkg::REG_RESET}};
            wr_q     <= '0;
            wr_tgl_q <= 1'b0;
        end
        else
        begin
            regs_q   <= regs_d;
            wr_q     <= wr_d;
            wr_tgl_q <= wr_tgl_d;
        end
    end

    // ********************************************************
    // Serial clock domain: read data on falling edges
    // ********************************************************
    logic       out_q;
    logic       out_d;
    logic       sdio_oe_q;
    logic       sdio_oe_d;
    logic       sep_oe_q;
    logic       sep_oe_d;
    logic [7:0] rd_byte;
    logic       drive;

    always_comb
    begin
        rd_byte   = addr_ok ? regs_q[port_q.addr] : 8'h00;
        drive     = (port_q.phase == scp_pkg::PH_DATA) && port_q.rd;
        out_d     = lsb_first ? rd_byte[port_q.bit_cnt]
                              : rd_byte[3'(scp_pkg::BIT_LAST - port_q.bit_cnt)];
        sdio_oe_d = drive && !input_only;
        sep_oe_d  = drive && input_only;
    end

    // Not cleared by deselect, so a resumed read drives its pending bit at once
    always_ff @(negedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            out_q     <= 1'b0;
            sdio_oe_q <= 1'b0;
            sep_oe_q  <= 1'b0;
        end
        else
        begin
            out_q     <= out_d;
            sdio_oe_q <= sdio_oe_d;
            sep_oe_q  <= sep_oe_d;
        end
    end

    assign sdio_out          = out_q;
    assign serial_out_pin    = out_q;
    assign sdio_oe           = sdio_oe_q & ~cs_n;
    assign serial_out_pin_oe = sep_oe_q & ~cs_n;

    // ********************************************************
    // Core domain: register image via toggle crossing
    // ********************************************************
    logic [2:0]               tgl_sync_q;
    logic [2:0]               tgl_sync_d;
    logic [NUM_REGS-1:0][7:0] bank_q;
    logic [NUM_REGS-1:0][7:0] bank_d;
    logic                     upd_q;
    logic                     upd_d;

    always_comb
    begin
        tgl_sync_d = {tgl_sync_q[1:0], wr_tgl_q};
        bank_d     = bank_q;
        upd_d      = 1'b0;
        // Write event fields are held stable for many serial edges after the toggle
        if (tgl_sync_q[2] != tgl_sync_q[1])
        begin
            bank_d[wr_q.addr] = wr_q.data;
            upd_d             = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tgl_sync_q <= 3'h0;
            bank_q     <= {NUM_REGS{scp_pkg::REG_RESET}};
            upd_q      <= 1'b0;
        end
        else
        begin
            tgl_sync_q <= tgl_sync_d;
            bank_q     <= bank_d;
            upd_q      <= upd_d;
        end
    end

    assign reg_bank   = bank_q;
    assign reg_update = upd_q;

    // ********************************************************
    // Assertions
    // ********************************************************
    logic instr_done;
    logic data_done;
    assign instr_done = !cs_n && port_q.phase == scp_pkg::PH_INSTR && port_q.bit_cnt == scp_pkg::BIT_LAST;
    assign data_done  = !cs_n && port_q.phase == scp_pkg::PH_DATA && port_q.bit_cnt == scp_pkg::BIT_LAST;

    AST_INSTR_LEN: assert property (@(posedge sclk) disable iff (!link_rst_n)
        instr_done |=> port_q.phase == scp_pkg::PH_DATA && port_q.bit_cnt == scp_pkg::BIT_FIRST)
        else $error("instruction phase did not end after eight edges");
    AST_RD_DIR: assert property (@(posedge sclk) disable iff (!link_rst_n)
        instr_done |=> port_q.rd == $past(din_byte[scp_pkg::INSTR_RD_BIT]))
        else $error("direction bit not taken from instruction");
    AST_BYTE_CNT: assert property (@(posedge sclk) disable iff (!link_rst_n)
        instr_done |=> port_q.bytes_left == $past(din_byte[scp_pkg::INSTR_CNT_MSB:scp_pkg::INSTR_CNT_LSB]))
        else $error("byte count not taken from instruction");
    AST_START_ADDR: assert property (@(posedge sclk) disable iff (!link_rst_n)
        instr_done |=> port_q.addr == $past(din_byte[scp_pkg::INSTR_ADDR_MSB:0]))
        else $error("start address not taken from instruction");
    AST_CYCLE_END: assert property (@(posedge sclk) disable iff (!link_rst_n)
        data_done && port_q.bytes_left == scp_pkg::BYTES_LAST |=> port_q.phase == scp_pkg::PH_INSTR)
        else $error("cycle did not return to instruction phase");
    AST_SUSPEND: assert property (@(posedge sclk) disable iff (!link_rst_n)
        cs_n |=> $stable(port_q.bit_cnt) && $stable(port_q.addr) && $stable(port_q.phase))
        else $error("port advanced while deselected");
    AST_WRAP_DOWN: assert property (@(posedge sclk) disable iff (!link_rst_n)
        data_done && !lsb_first && port_q.addr == scp_pkg::ADDR_FIRST |=> port_q.addr == scp_pkg::ADDR_LAST)
        else $error("address did not wrap down");
    AST_WRAP_UP: assert property (@(posedge sclk) disable iff (!link_rst_n)
        data_done && lsb_first && port_q.addr == scp_pkg::ADDR_LAST |=> port_q.addr == scp_pkg::ADDR_FIRST)
        else $error("address did not wrap up");
    AST_HIZ: assert property (@(negedge sclk) disable iff (!rst_n)
        cs_n |-> !sdio_oe && !serial_out_pin_oe)
        else $error("output driven while deselected");
    AST_ONE_PIN: assert property (@(negedge sclk) disable iff (!rst_n)
        !input_only |-> !serial_out_pin_oe)
        else $error("separate output driven in shared-pin mode");
    AST_OE_SINGLE: assert property (@(negedge sclk) disable iff (!rst_n)
        !(sdio_oe && serial_out_pin_oe))
        else $error("both data outputs driven at once");
    AST_OE_READ: assert property (@(posedge sclk) disable iff (!link_rst_n)
        !cs_n && port_q.phase == scp_pkg::PH_DATA && port_q.rd |-> sdio_oe || serial_out_pin_oe)
        else $error("read data not driven during read data phase");
    AST_OE_IDLE: assert property (@(posedge sclk) disable iff (!link_rst_n)
        port_q.phase == scp_pkg::PH_INSTR || !port_q.rd |-> !sdio_oe && !serial_out_pin_oe)
        else $error("output driven outside a read data phase");
    // Written byte must land at the address in use for that byte
    AST_WR_DATA: assert property (@(posedge sclk) disable iff (!link_rst_n)
        data_done && !port_q.rd && addr_ok |=> regs_q[$past(port_q.addr)] == $past(din_byte))
        else $error("written byte not stored at current address");
    // Bit order follows a config write from the very next edge
    AST_CFG_NOW: assert property (@(posedge sclk) disable iff (!link_rst_n)
        data_done && !port_q.rd && port_q.addr == scp_pkg::CFG_ADDR
        |=> lsb_first == $past(din_byte[scp_pkg::CFG_LSB_FIRST_BIT]))
        else $error("bit order change not applied at once");
    AST_RESYNC_KEEP: assert property (@(posedge sclk) disable iff (!rst_n)
        port_resync |=> regs_q == $past(regs_q))
        else $error("registers changed during resync");
    AST_IMAGE: assert property (@(posedge clock) disable iff (!rst_n)
        tgl_sync_q[2] != tgl_sync_q[1] |=> reg_update && reg_bank[wr_q.addr] == wr_q.data)
        else $error("register image not updated");

endmodule

// >>> scp_host.sv
`timescale 1ns/100ps

// ****************************************
// Serial master model, 12 ns link clock
// ****************************************
module scp_host (
    output logic      sclk,              // Serial clock, idle low; pulse toggles it even while deselected
    output logic      cs_n,              // Chip select, active low
    output logic      sdio_in,           // Shared pin level seen by device
    input  wire logic sdio_out,          // Device shared pin value
    input  wire logic sdio_oe,           // Device shared pin enable
    input  wire logic serial_out_pin,    // Device separate output
    input  wire logic serial_out_pin_oe  // Device separate output enable
);
    logic drv_en;
    logic drv;
    logic last_v;
    logic sdio_seen;
    logic so_seen;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv_en = 1'b1;
        drv = 1'b0;
        last_v = 1'b0;
        sdio_seen = 1'b0;
        so_seen = 1'b0;
    end

    // Undriven line toggles instead of holding a stale level
    assign sdio_in = drv_en ? drv : (sdio_oe ? sdio_out : ~last_v);

    always @(negedge sclk) last_v <= sdio_in;

    always @(posedge sclk)
    begin
        sdio_seen <= sdio_seen | sdio_oe;
        so_seen <= so_seen | serial_out_pin_oe;
    end

    task automatic xbyte(input logic [7:0] b, input logic lsb, input logic sep, input logic wr,
                         output logic [7:0] r);
        int k;
        for (int i = 0; i < 8; i++)
        begin
            k = lsb ? i : 7 - i;
            drv_en = wr;
            drv = b[k];
            #6 sclk = 1'b1;
            r[k] = sep ? (serial_out_pin_oe ? serial_out_pin : 1'bz) : sdio_in;
            #6 sclk = 1'b0;
        end
        drv_en = 1'b1;
    endtask

    task automatic pulse(input int n);
        for (int i = 0; i < n; i++)
        begin
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
        end
    endtask

    task automatic cycle(input logic [7:0] ins, input logic [31:0] d, input int n, input logic lsb,
                         input logic sep, output logic [31:0] r);
        logic [7:0] t;
        cs_n = 1'b0;
        sdio_seen = 1'b0;
        so_seen = 1'b0;
        #6;
        xbyte(ins, lsb, sep, 1'b1, t);
        for (int j = 0; j < n; j++)
        begin
            xbyte(d[8*j+:8], lsb, sep, !ins[7], t);
            r[8*j+:8] = t;
        end
        #6 cs_n = 1'b1;
        #6;
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps

module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic port_resync = 1'b0;
    logic sclk;
    logic cs_n;
    logic sdio_in;
    logic sdio_out;
    logic sdio_oe;
    logic serial_out_pin;
    logic serial_out_pin_oe;
    logic [scp_pkg::NUM_REGS-1:0][7:0] reg_bank;
    logic reg_update;
    logic [31:0] r;
    logic [7:0] t;
    int bad_count = 0;
    int n_checks = 0;
    int upd_n = 0;
    int cyc = 0;

    always #5 clock = ~clock;

    scp_serial_control_port dut (.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .port_resync(port_resync), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .serial_out_pin(serial_out_pin), .serial_out_pin_oe(serial_out_pin_oe),
        .reg_bank(reg_bank), .reg_update(reg_update));

    scp_host host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin), .serial_out_pin_oe(serial_out_pin_oe));

    always @(posedge clock)
    begin
        if (reg_update === 1'b1)
            upd_n++;
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle();
        repeat (10) @(negedge clock);
    endtask

    task automatic t_write();
        host.cycle(8'h05, 32'hA5, 1, 1'b0, 1'b0, r);
        settle();
        chk(reg_bank[5], 8'hA5);
        chk(upd_n, 1);
        host.cycle({1'b0, 2'b11, 5'h01}, 32'h4433_0011, 4, 1'b0, 1'b0, r);
        settle();
        chk({reg_bank[1], reg_bank[0], reg_bank[25], reg_bank[24]}, 32'h1100_3344);
        chk(upd_n, 5);
    endtask

    task automatic t_read();
        host.cycle({1'b1, 2'b01, 5'h19}, 32'h0, 2, 1'b0, 1'b0, r);
        chk(r[15:0], 16'h4433);
        chk({host.sdio_seen, host.so_seen}, 2'b10);
        chk({sdio_oe, serial_out_pin_oe}, 2'b00);
    endtask

    task automatic t_suspend();
        host.cs_n = 1'b0;
        host.xbyte(8'h07, 1'b0, 1'b0, 1'b1, t);
        host.cs_n = 1'b1;
        host.pulse(5);
        host.cs_n = 1'b0;
        host.xbyte(8'h3C, 1'b0, 1'b0, 1'b1, t);
        host.xbyte(8'h87, 1'b0, 1'b0, 1'b1, t);
        host.cs_n = 1'b1;
        #3;
        chk({sdio_oe, serial_out_pin_oe}, 2'b00);
        host.pulse(3);
        host.cs_n = 1'b0;
        host.xbyte(8'h00, 1'b0, 1'b0, 1'b0, t);
        host.cs_n = 1'b1;
        settle();
        chk(reg_bank[7], 8'h3C);
        chk(t, 8'h3C);
    endtask

    task automatic t_resync();
        host.cs_n = 1'b0;
        host.drv = 1'b1;
        host.pulse(3);
        @(negedge clock) port_resync = 1'b1;
        host.pulse(8);
        @(negedge clock) port_resync = 1'b0;
        host.cs_n = 1'b1;
        host.cycle(8'h08, 32'h5A, 1, 1'b0, 1'b0, r);
        settle();
        chk(reg_bank[8], 8'h5A);
        chk({reg_bank[5], reg_bank[7]}, 16'hA53C);
    endtask

    task automatic t_extra();
        host.cs_n = 1'b0;
        host.xbyte(8'h09, 1'b0, 1'b0, 1'b1, t);
        host.xbyte(8'h11, 1'b0, 1'b0, 1'b1, t);
        host.xbyte(8'h0A, 1'b0, 1'b0, 1'b1, t);
        host.xbyte(8'h22, 1'b0, 1'b0, 1'b1, t);
        host.cs_n = 1'b1;
        settle();
        chk({reg_bank[9], reg_bank[10]}, 16'h1122);
    endtask

    task automatic t_lsb();
        host.cycle(8'h00, 32'hC0, 1, 1'b0, 1'b0, r);
        settle();
        chk(reg_bank[0], 8'hC0);
        host.cycle({1'b0, 2'b01, 5'h19}, 32'hC077, 2, 1'b1, 1'b1, r);
        settle();
        chk({reg_bank[25], reg_bank[0]}, 16'h77C0);
        host.cycle({1'b1, 2'b01, 5'h18}, 32'h0, 2, 1'b1, 1'b1, r);
        chk(r[15:0], 16'h7744);
        chk({host.sdio_seen, host.so_seen}, 2'b01);
        host.cycle(8'h00, 32'h00, 1, 1'b1, 1'b1, r);
        settle();
        chk(reg_bank[0], 8'h00);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        chk(reg_bank[0], scp_pkg::REG_RESET);
        chk({sdio_oe, serial_out_pin_oe}, 2'b00);
        t_write();
        t_read();
        t_suspend();
        t_resync();
        t_extra();
        t_lsb();
        report_and_stop();
    end
endmodule
